// [hdl/ccir_top.sv]
// card config index registers: index/data ports, page match, card status, shared pins
// assumes host i/o strobes are synchronous one-cycle pulses on clk
`timescale 1ns/1ps
module ccir_top
  import ccir_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host i/o bus
  input ccir_io_req_t io_req,
  output ccir_io_rsp_t io_rsp,
  // fixed port decodes
  output logic kbd_buf_sel,
  output logic kbd_cmd_sel,
  output logic clk_addr_sel,
  output logic clk_data_sel,
  // card inputs
  input wire logic card_busy_status_n,
  input wire logic card_write_protect,
  input wire logic card_detect_a_n,
  input wire logic card_detect_b_n,
  // shared battery detect / ide enable pins
  input wire logic batt_detect_a_or_ide_lo_en_in,
  output logic batt_detect_a_or_ide_lo_en_out,
  output logic batt_detect_a_or_ide_lo_en_oe_n,
  input wire logic batt_detect_b_or_ide_hi_en_in,
  output logic batt_detect_b_or_ide_hi_en_out,
  output logic batt_detect_b_or_ide_hi_en_oe_n,
  // ide byte requests from chip select decode
  input wire logic ide_lo_req,
  input wire logic ide_hi_req,
  // memory cycle
  input wire logic mem_cycle,
  input wire logic [19:14] sys_addr,
  input wire logic sys_a0,
  input wire logic sys_bhe_n,
  // card control outputs
  output logic [3:0] page_hit,
  output logic card_enable_one_n,
  output logic card_enable_two_n,
  output logic card_attr_select,
  output logic card_mode
);
  localparam int CW = $clog2(DEB_CYCLES + 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---- mode capture at reset release
  ccir_mode_t mode;
  ccir_mode_t next_mode;

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_WAIT: begin
        // see RULE_20
        next_mode = card_detect_b_n ? MODE_CHIPSEL : MODE_CARD;
      end
      MODE_CARD: next_mode = MODE_CARD;
      MODE_CHIPSEL: next_mode = MODE_CHIPSEL;
      default: next_mode = MODE_WAIT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= MODE_WAIT;
    end else begin
      mode <= next_mode;
    end
  end

  logic chipsel_mode;
  assign chipsel_mode = (mode == MODE_CHIPSEL);
  assign card_mode = (mode == MODE_CARD);

  AST_MODE_LATCHED: assert property ( // see RULE_20
    (mode != MODE_WAIT) |=> $stable(mode))
    else $error("mode changed after capture");

  // ---- address decode
  logic acc;
  logic wr_idx1;
  logic wr_dat1;
  logic wr_idx2;
  logic wr_dat2;
  logic rd_dat2;

  assign acc = io_req.wr | io_req.rd;
  // see RULE_08
  assign kbd_buf_sel = acc && (io_req.addr == KBD_IO_BUF_ADDR);
  assign kbd_cmd_sel = acc && (io_req.addr == KBD_STAT_CMD_ADDR);
  // see RULE_09
  assign clk_addr_sel = acc && (io_req.addr == CLK_ADDR_PORT_ADDR);
  assign clk_data_sel = acc && (io_req.addr == CLK_DATA_PORT_ADDR);
  // see RULE_05
  assign wr_idx1 = io_req.wr && (io_req.addr == FIRST_INDEX_ADDR);
  assign wr_dat1 = io_req.wr && (io_req.addr == FIRST_DATA_ADDR);
  // see RULE_06
  assign wr_idx2 = io_req.wr && (io_req.addr == SECOND_INDEX_ADDR);
  assign wr_dat2 = io_req.wr && (io_req.addr == SECOND_DATA_ADDR);
  // see RULE_07
  assign rd_dat2 = io_req.rd && (io_req.addr == SECOND_DATA_ADDR);

  AST_KBD_DECODE: assert property ( // see RULE_08
    kbd_cmd_sel |-> acc && io_req.addr[7:0] == 8'h64 && !kbd_buf_sel)
    else $error("keyboard decode wrong");

  AST_CLK_DECODE: assert property ( // see RULE_09
    (io_req.wr && io_req.addr == 16'h0071) |-> clk_data_sel && !clk_addr_sel)
    else $error("clock decode wrong");

  // ---- index ports
  logic [7:0] idx1;
  logic [7:0] idx2;
  logic [7:0] next_idx1;
  logic [7:0] next_idx2;

  always_comb begin
    // see RULE_03 see RULE_22
    next_idx1 = wr_idx1 ? io_req.wdata : idx1;
    next_idx2 = wr_idx2 ? io_req.wdata : idx2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx1 <= INDEX_RESET;
      idx2 <= INDEX_RESET;
    end else begin
      idx1 <= next_idx1;
      idx2 <= next_idx2;
    end
  end

  AST_INDEX_HOLDS: assert property ( // see RULE_22
    !wr_idx1 && !wr_idx2 |=> $stable(idx1) && $stable(idx2))
    else $error("index changed without write");

  // ---- page match registers
  logic [PAGE_BITS-1:0] page [4];
  logic [PAGE_BITS-1:0] next_page [4];
  logic [7:0] page_idx [4];

  assign page_idx[0] = IDX_CARD_PAGE_0_MATCH;
  assign page_idx[1] = IDX_CARD_PAGE_1_MATCH;
  assign page_idx[2] = IDX_CARD_PAGE_2_MATCH;
  assign page_idx[3] = IDX_CARD_PAGE_3_MATCH;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_page[i] = page[i];
      // see RULE_04 see RULE_10 see RULE_11
      if (wr_dat1 && idx1 == page_idx[i]) begin
        next_page[i] = io_req.wdata[PAGE_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        page[i] <= PAGE_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        page[i] <= next_page[i];
      end
    end
  end

  sequence s_sel_card_page_2_match;
    wr_idx1 && io_req.wdata == 8'h34;
  endsequence

  sequence s_write_first_data_port;
    wr_dat1 && !wr_idx1;
  endsequence

  AST_PAGE_PATH: assert property ( // see RULE_10
    s_sel_card_page_2_match ##1 s_write_first_data_port |=> page[2] == $past(io_req.wdata[5:0]))
    else $error("page 2 not written through first pair");

  AST_PAGE_OTHER: assert property ( // see RULE_04
    (wr_dat1 && idx1 == 8'h30) |=> $stable(page[1]) && $stable(page[3]))
    else $error("data write hit wrong page");

  // ---- card status control bits
  logic attr_bit;
  logic byte_bit;
  logic next_attr_bit;
  logic next_byte_bit;

  always_comb begin
    next_attr_bit = attr_bit;
    next_byte_bit = byte_bit;
    // see RULE_04 see RULE_12
    if (wr_dat2 && idx2 == IDX_STATUS) begin
      next_attr_bit = io_req.wdata[STAT_ATTR];
      next_byte_bit = io_req.wdata[STAT_BYTE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      attr_bit <= ATTR_RESET;
      byte_bit <= BYTE_RESET;
    end else begin
      attr_bit <= next_attr_bit;
      byte_bit <= next_byte_bit;
    end
  end

  // see RULE_16
  assign card_attr_select = attr_bit;

  AST_ATTR_PIN: assert property ( // see RULE_16
    (wr_dat2 && idx2 == 8'h1a) |=> card_attr_select == $past(io_req.wdata[3]))
    else $error("attribute pin does not follow status bit");

  // ---- card detect debounce
  logic deb_q [2];
  logic [CW-1:0] deb_cnt [2];
  logic det_in [2];

  assign det_in[0] = card_detect_a_n;
  assign det_in[1] = card_detect_b_n;

  for (genvar g = 0; g < 2; g++) begin : g_deb
    logic next_q;
    logic [CW-1:0] next_cnt;

    always_comb begin
      next_q = deb_q[g];
      next_cnt = '0;
      // see RULE_21
      if (det_in[g] != deb_q[g]) begin
        if (deb_cnt[g] == CW'(DEB_CYCLES - 1)) begin
          next_q = det_in[g];
        end else begin
          next_cnt = deb_cnt[g] + CW'(1);
        end
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        deb_q[g] <= 1'b1;
        deb_cnt[g] <= '0;
      end else begin
        deb_q[g] <= next_q;
        deb_cnt[g] <= next_cnt;
      end
    end
  end

  AST_DEB_WAIT: assert property ( // see RULE_21
    $changed(deb_q[0]) |-> $past(deb_cnt[0]) == CW'(DEB_CYCLES - 1))
    else $error("debounce updated early");

  logic present_n;
  // see RULE_14
  assign present_n = !(!deb_q[0] && !deb_q[1]);

  AST_PRESENT: assert property ( // see RULE_14
    !present_n |-> !deb_q[0] && !deb_q[1])
    else $error("card present without both detects");

  // ---- status read and host response
  logic [7:0] status_val;
  logic [7:0] rd_val;
  ccir_io_rsp_t next_rsp;

  always_comb begin
    status_val = 8'h00;
    status_val[STAT_BUSY] = card_busy_status_n; // see RULE_13
    status_val[STAT_PRESENT] = present_n;
    status_val[STAT_WP] = card_write_protect; // see RULE_15
    status_val[STAT_ATTR] = attr_bit;
    status_val[STAT_BYTE] = byte_bit;
    status_val[STAT_BATTERY_DETECT_ONE] = batt_detect_a_or_ide_lo_en_in; // see RULE_18
    status_val[STAT_BATTERY_DETECT_TWO] = batt_detect_b_or_ide_hi_en_in;
    status_val[STAT_RSVD] = 1'b1; // see RULE_19
    rd_val = (idx2 == IDX_STATUS) ? status_val : UNMAPPED_READ;
    next_rsp.valid = rd_dat2;
    next_rsp.rdata = rd_dat2 ? rd_val : io_rsp.rdata;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rsp <= '{rdata: RDATA_RESET, valid: 1'b0};
    end else begin
      io_rsp <= next_rsp;
    end
  end

  sequence s_status_read;
    rd_dat2 && idx2 == 8'h1a;
  endsequence

  AST_STATUS_PINS: assert property ( // see RULE_13
    s_status_read |=> io_rsp.valid && io_rsp.rdata[0] == $past(card_busy_status_n)
      && io_rsp.rdata[2] == $past(card_write_protect))
    else $error("status pin bits wrong");

  AST_STATUS_RSVD: assert property ( // see RULE_19
    s_status_read |=> io_rsp.rdata[7] && io_rsp.rdata[6] == $past(batt_detect_b_or_ide_hi_en_in))
    else $error("status bit 7 or 6 wrong");

  AST_WO_SILENT: assert property ( // see RULE_07
    io_rsp.valid |-> $past(io_req.rd) && $past(io_req.addr) == 16'h00ed)
    else $error("answer to a write only port");

  // ---- memory card access and shared pins
  logic [3:0] next_hit;
  logic next_ce1_n;
  logic next_ce2_n;
  logic next_lo_en;
  logic next_hi_en;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // see RULE_11
      next_hit[i] = mem_cycle && card_mode && (sys_addr == page[i]);
    end
    next_ce1_n = 1'b1;
    next_ce2_n = 1'b1;
    if (|next_hit) begin
      // see RULE_17
      if (byte_bit) begin
        next_ce1_n = 1'b0;
      end else begin
        next_ce1_n = sys_a0;
        next_ce2_n = sys_bhe_n;
      end
    end
    next_lo_en = chipsel_mode && ide_lo_req;
    next_hi_en = chipsel_mode && ide_hi_req;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_hit <= 4'h0;
      card_enable_one_n <= 1'b1;
      card_enable_two_n <= 1'b1;
      batt_detect_a_or_ide_lo_en_out <= 1'b0;
      batt_detect_b_or_ide_hi_en_out <= 1'b1;
    end else begin
      page_hit <= next_hit;
      card_enable_one_n <= next_ce1_n;
      card_enable_two_n <= next_ce2_n;
      batt_detect_a_or_ide_lo_en_out <= next_lo_en; // see RULE_02
      batt_detect_b_or_ide_hi_en_out <= !next_hi_en; // see RULE_01
    end
  end

  // see RULE_01 see RULE_02
  assign batt_detect_a_or_ide_lo_en_oe_n = !chipsel_mode;
  assign batt_detect_b_or_ide_hi_en_oe_n = !chipsel_mode;

  AST_BYTE_MODE: assert property ( // see RULE_17
    (|next_hit && byte_bit) |=> !card_enable_one_n && card_enable_two_n)
    else $error("byte mode access used enable two");

  AST_CARD_INPUTS: assert property ( // see RULE_01
    card_mode |-> batt_detect_b_or_ide_hi_en_oe_n && batt_detect_a_or_ide_lo_en_oe_n)
    else $error("shared pin driven in card mode");

  AST_IDE_DRIVE: assert property ( // see RULE_02
    chipsel_mode && ide_lo_req |=> !batt_detect_a_or_ide_lo_en_oe_n
      && batt_detect_a_or_ide_lo_en_out)
    else $error("ide low enable not driven");
endmodule

// [inc/ccir_pkg.sv]
// constants, field layout and carrier types for the card config index registers
// assumes a synchronous host i/o strobe interface on the block clock
// Operation
// (RULE_01) card mode: shared pin two is a card input; chip select mode: drives ide high enable.
// (RULE_02) card mode: shared pin one is a card input; chip select mode: drives ide low enable.
// (RULE_03) host writes an 8-bit index; the next data access uses it as address.
// (RULE_04) each data port reaches the register its paired index selects.
// (RULE_05) first index port at e8, first data port at ea.
// (RULE_06) second index port at ec, second data port at ed.
// (RULE_07) index ports and first data port are write only; second data port reads too.
// (RULE_08) keyboard buffer answers at 0060, keyboard status/command at 0064.
// (RULE_09) clock address port answers at 0070, clock data port at 0071.
// (RULE_10) four page match registers sit at first-pair indexes 30, 32, 34, 36.
// (RULE_11) page match holds 6 bits compared to address 19..14; bits 7..6 read 1 (code stores 6 bits only and has no page match read path).
// (RULE_12) card status register sits at second-pair index 1a.
// (RULE_13) status bit 0 gives the busy pin level taken at the read.
// (RULE_14) status bit 1 low only when both debounced card detects are low.
// (RULE_15) status bit 2 gives the write protect pin taken at the read.
// (RULE_16) status bit 3 drives the attribute select pin continuously.
// (RULE_17) status bit 4 set makes every card access a byte access on enable one.
// (RULE_18) status bits 5 and 6 give battery detects one and two at the read.
// (RULE_19) status bit 7 is reserved and always reads 1.
// (RULE_20) card detect b level at reset release picks card or chip select mode.
// (RULE_21) card detects must hold steady a fixed cycle count before the filter updates.
// (RULE_22) index ports keep their value until rewritten or reset.
package ccir_pkg;
  localparam logic [15:0] KBD_IO_BUF_ADDR = 16'h0060;
  localparam logic [15:0] KBD_STAT_CMD_ADDR = 16'h0064;
  localparam logic [15:0] CLK_ADDR_PORT_ADDR = 16'h0070;
  localparam logic [15:0] CLK_DATA_PORT_ADDR = 16'h0071;
  localparam logic [15:0] FIRST_INDEX_ADDR = 16'h00e8;
  localparam logic [15:0] FIRST_DATA_ADDR = 16'h00ea;
  localparam logic [15:0] SECOND_INDEX_ADDR = 16'h00ec;
  localparam logic [15:0] SECOND_DATA_ADDR = 16'h00ed;
  localparam logic [7:0] IDX_STATUS = 8'h1a;
  localparam logic [7:0] IDX_CARD_PAGE_0_MATCH = 8'h30;
  localparam logic [7:0] IDX_CARD_PAGE_1_MATCH = 8'h32;
  localparam logic [7:0] IDX_CARD_PAGE_2_MATCH = 8'h34;
  localparam logic [7:0] IDX_CARD_PAGE_3_MATCH = 8'h36;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PRESENT = 1;
  localparam int STAT_WP = 2;
  localparam int STAT_ATTR = 3;
  localparam int STAT_BYTE = 4;
  localparam int STAT_BATTERY_DETECT_ONE = 5;
  localparam int STAT_BATTERY_DETECT_TWO = 6;
  localparam int STAT_RSVD = 7;
  localparam int PAGE_BITS = 6;
  localparam logic [1:0] PAGE_FIXED = 2'h3;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [PAGE_BITS-1:0] PAGE_RESET = 6'h00;
  localparam logic ATTR_RESET = 1'b0;
  localparam logic BYTE_RESET = 1'b0;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam int DEBOUNCE_CYCLES = 16;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ccir_io_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic valid;
  } ccir_io_rsp_t;

  typedef enum {MODE_WAIT, MODE_CARD, MODE_CHIPSEL} ccir_mode_t;
endpackage

// [bench/ccir_host_model.sv]
// host model: issues one-cycle i/o strobes at the index and data ports
// assumes the device answers a data port read within a few clock cycles
`timescale 1ns/1ps
module ccir_host_model
  import ccir_pkg::*;
(
  // clock
  input wire logic clk,
  // host bus
  output ccir_io_req_t io_req,
  input ccir_io_rsp_t io_rsp
);
  initial io_req = '0;

  // idle address and data turn over so a stale value never passes for a live one
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  // index first, then data at the paired port
  task automatic wr_reg(input logic [15:0] ia, input logic [7:0] idx, input logic [7:0] d);
    cyc(ia, 1'b1, idx);
    cyc((ia == FIRST_INDEX_ADDR) ? FIRST_DATA_ADDR : SECOND_DATA_ADDR, 1'b1, d);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    cyc(a, 1'b0, 8'h00);
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (io_rsp.valid === 1'b1) begin
        ok = 1'b1;
        q = io_rsp.rdata;
      end
      // always end on an edge so callers drive their next inputs on it
      @(posedge clk);
    end
  endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the card config index registers
// assumes ccir_pkg and the host model are compiled before it
`timescale 1ns/1ps
module testbench
  import ccir_pkg::*;
;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] val;
    logic [5:0] sa;
    logic [3:0] hit;
  } ccir_row_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  ccir_io_req_t io_req;
  ccir_io_rsp_t io_rsp;
  logic busy_n = 1'b0, wp = 1'b0, cda_n = 1'b0, cdb_n = 1'b0, battery_detect_one = 1'b0, battery_detect_two = 1'b0;
  logic ide_lo = 1'b0, ide_hi = 1'b0, mem = 1'b0, a0 = 1'b0;
  logic [5:0] sa = 6'h00;
  logic lo_out, lo_oe_n, hi_out, hi_oe_n, ce1_n, ce2_n, attr, cmode;
  logic [3:0] hit, sel;
  logic [7:0] q;
  logic ok;
  int n_mismatch = 0;
  int samples_checked = 0;
  ccir_row_t rows [4] = '{'{IDX_CARD_PAGE_0_MATCH, 8'hc5, 6'h05, 4'h1}, '{IDX_CARD_PAGE_1_MATCH, 8'hea, 6'h2a, 4'h2},
    '{IDX_CARD_PAGE_2_MATCH, 8'hff, 6'h3f, 4'h4}, '{IDX_CARD_PAGE_3_MATCH, 8'h11, 6'h11, 4'h8}};
  logic [15:0] fixed [4] = '{KBD_IO_BUF_ADDR, KBD_STAT_CMD_ADDR, CLK_ADDR_PORT_ADDR,
    CLK_DATA_PORT_ADDR};

  always #12.5 clk = ~clk;

  ccir_host_model host (.clk(clk), .io_req(io_req), .io_rsp(io_rsp));

  ccir_top #(.DEB_CYCLES(2)) uut (.clk(clk), .rst(rst), .io_req(io_req), .io_rsp(io_rsp),
    .kbd_buf_sel(sel[0]), .kbd_cmd_sel(sel[1]), .clk_addr_sel(sel[2]), .clk_data_sel(sel[3]),
    .card_busy_status_n(busy_n), .card_write_protect(wp), .card_detect_a_n(cda_n),
    .card_detect_b_n(cdb_n), .batt_detect_a_or_ide_lo_en_in(lo_oe_n ? battery_detect_one : lo_out),
    .batt_detect_a_or_ide_lo_en_out(lo_out), .batt_detect_a_or_ide_lo_en_oe_n(lo_oe_n),
    .batt_detect_b_or_ide_hi_en_in(hi_oe_n ? battery_detect_two : hi_out),
    .batt_detect_b_or_ide_hi_en_out(hi_out), .batt_detect_b_or_ide_hi_en_oe_n(hi_oe_n),
    .ide_lo_req(ide_lo), .ide_hi_req(ide_hi), .mem_cycle(mem), .sys_addr(sa), .sys_a0(a0),
    .sys_bhe_n(1'b0), .page_hit(hit), .card_enable_one_n(ce1_n), .card_enable_two_n(ce2_n),
    .card_attr_select(attr), .card_mode(cmode));

  task automatic final_report();
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // a read that never answers ends the run
  task automatic rd_stat(input logic [7:0] exp);
    host.rd(SECOND_DATA_ADDR, q, ok);
    if (!ok) begin
      n_mismatch++;
      final_report();
    end
    check("status", q, exp);
  endtask

  function automatic logic [7:0] st(input logic byt, input logic at);
    return {1'b1, battery_detect_two, battery_detect_one, byt, at, wp, cda_n | cdb_n, busy_n};
  endfunction

  task automatic do_reset(input logic cd);
    rst <= 1'b1;
    cdb_n <= cd;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic mem_chk(input logic [5:0] s, input logic lo, input logic [3:0] eh,
    input logic [1:0] ec);
    @(posedge clk);
    mem <= 1'b1;
    sa <= s;
    a0 <= lo;
    @(posedge clk);
    #1;
    check("page_hit", 8'(hit), 8'(eh));
    if (eh != 4'h0) check("enables", 8'({ce2_n, ce1_n}), 8'(ec));
    @(posedge clk);
    mem <= 1'b0;
  endtask

  initial begin
    do_reset(1'b0);
    check("card_mode", 8'(cmode), 8'h01);
    check("pin_oe_n", 8'({hi_oe_n, lo_oe_n}), 8'h03);
    host.wr_reg(SECOND_INDEX_ADDR, IDX_STATUS, 8'h80);
    rd_stat(st(1'b0, 1'b0));
    foreach (rows[i]) begin
      host.wr_reg(FIRST_INDEX_ADDR, rows[i].idx, rows[i].val);
      mem_chk(rows[i].sa, 1'b0, rows[i].hit, 2'h0);
    end
    mem_chk(6'h00, 1'b0, 4'h0, 2'h0);
    host.wr_reg(FIRST_INDEX_ADDR, 8'h31, 8'h00);
    mem_chk(6'h05, 1'b0, 4'h1, 2'h0);
    host.cyc(FIRST_INDEX_ADDR, 1'b1, IDX_CARD_PAGE_0_MATCH);
    host.cyc(FIRST_DATA_ADDR, 1'b1, 8'h00);
    host.cyc(FIRST_DATA_ADDR, 1'b1, 8'hd1);
    mem_chk(6'h11, 1'b0, 4'h9, 2'h0);
    // status write sets the attribute bit; reads then follow the busy, write protect and battery pins
    host.wr_reg(SECOND_INDEX_ADDR, IDX_STATUS, 8'h88);
    @(posedge clk);
    check("attr", 8'(attr), 8'h01);
    for (int p = 0; p < 4; p++) begin
      busy_n <= p[0];
      wp <= p[1];
      battery_detect_one <= ~p[0];
      battery_detect_two <= p[1];
      @(posedge clk);
      rd_stat(st(1'b0, 1'b1));
    end
    host.cyc(SECOND_DATA_ADDR, 1'b1, 8'h98);
    mem_chk(6'h11, 1'b1, 4'h9, 2'h2);
    cda_n <= 1'b1;
    @(posedge clk);
    cda_n <= 1'b0;
    @(posedge clk);
    rd_stat(st(1'b1, 1'b1));
    cda_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd_stat(st(1'b1, 1'b1));
    for (int i = 0; i < 3; i++) begin
      host.rd(16'h00e8 + 16'(2 * i), q, ok);
      check("wo_valid", 8'(ok), 8'h00);
    end
    host.cyc(SECOND_INDEX_ADDR, 1'b1, IDX_CARD_PAGE_0_MATCH);
    rd_stat(UNMAPPED_READ);
    foreach (fixed[i]) begin
      fork
        host.cyc(fixed[i], 1'b0, 8'h00);
        begin
          @(posedge clk);
          #1;
          check("fixed_sel", 8'(sel), 8'(4'h1 << i));
        end
      join
    end
    do_reset(1'b1);
    check("card_mode", 8'(cmode), 8'h00);
    check("pin_oe_n", 8'({hi_oe_n, lo_oe_n}), 8'h00);
    for (int i = 0; i < 2; i++) begin
      ide_lo <= !i[0];
      ide_hi <= i[0];
      @(posedge clk);
      @(posedge clk);
      check("ide_enables", 8'({hi_out, lo_out}), 8'({!i[0], !i[0]}));
    end
    mem_chk(6'h00, 1'b0, 4'h0, 2'h0);
    final_report();
  end
endmodule
